/* File: rtl/lcd_pkg.sv */
// Package: register map, field positions, reset values and timing for the LCD control block
package lcd_pkg;
   // Register indices; the bus byte address is four times the index
   localparam logic [11:0] LCD_IDX_PUMP       = 12'h0013;
   localparam logic [11:0] LCD_IDX_MODE       = 12'h0014;
   localparam logic [11:0] LCD_IDX_DISP       = 12'h001d;
   localparam logic [11:0] LCD_IDX_STATUS     = 12'h0020;
   localparam logic [11:0] LCD_IDX_RAM_BASE   = 12'h0300;
   localparam logic [11:0] LCD_IDX_RAM_LAST   = 12'h036f;
   // Field positions
   localparam int LCD_PUMP_OFF_BIT  = 2;
   localparam int LCD_BLANK_BIT     = 3;
   localparam int LCD_LOW_VOLTAGE_RESET_FLAG_BIT      = 2;
   localparam int LCD_COM4_BIT      = 2;
   localparam int LCD_BANK_BIT      = 3;
   // Reset values
   localparam logic [3:0] LCD_PUMP_RST = 4'h4;
   localparam logic [3:0] LCD_MODE_RST = 4'h0;
   localparam logic [3:0] LCD_DISP_RST = 4'h0;
   // Clock and timing
   localparam int LCD_HCLK_KHZ      = 250000;
   localparam int LCD_PUMP_KHZ      = 4;
   localparam int LCD_PUMP_HALF     = LCD_HCLK_KHZ / (2 * LCD_PUMP_KHZ);
   // Frame tick periods in ns of one common slot, per clock option
   localparam int LCD_SLOT_NS_XTAL  = 3906250;
   localparam int LCD_SLOT_NS_RC32  = 4000000;
   localparam int LCD_SLOT_NS_RC200 = 3840000;
   localparam int LCD_HCLK_NS       = 4;
   typedef enum logic [1:0] {
      LCD_CK_RC_XTAL = 2'b00,
      LCD_CK_RC_RC32 = 2'b01,
      LCD_CK_XTAL    = 2'b10,
      LCD_CK_RC200   = 2'b11
   } lcd_ck_t;
endpackage

/* File: rtl/lcd_driver_control.sv */
// LCD driver control: AHB-Lite registers, display RAM, pump clock and common/segment scan
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Pump off bit 2 of pump register; 1 stops pump; reset stopped.
// - Blank bit 3 of display register; 1 blanks; reset shows.
// - Segment count field: 00 gives 56, 01 gives 52, 1x gives 48 segments.
// - Mode bit 2: 0 eight commons, 1 four commons with 5-8 freed.
// - Mode bit 3 selects data bank, low range at reset.
// - Pump clock is 4 kHz whatever clock option is active.
// - Options 00 and 01 take frame clock from low-frequency oscillator.
// - Option 10 uses crystal system clock, 32.00 Hz frames.
// - Option 11 uses 200 kHz RC clock, 32.55 Hz frames.
// - Pump stopped forces all commons and segments to ground.
// - Eight commons: 1/8 duty; four: 1/4 duty; both use 1/3 bias levels 1 and 2.
// - Driver keeps running and showing while CPU is halted.
// - In stop, driver runs only on options 00/01 when enabled.
// - Display RAM scanned autonomously while CPU still accesses it.
// - Display off drives all commons and segments low.
module lcd_driver_control
   import lcd_pkg::*;
#(
   parameter int         NSEG        = 56,
   parameter int         NCOM        = 8,
   parameter int         SLOT_XTAL   = LCD_SLOT_NS_XTAL / LCD_HCLK_NS,
   parameter int         SLOT_RC32   = LCD_SLOT_NS_RC32 / LCD_HCLK_NS,
   parameter int         SLOT_RC200  = LCD_SLOT_NS_RC200 / LCD_HCLK_NS,
   parameter logic [1:0] CK_OPTION   = 2'b00
)(
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [11:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic              cpu_stop,
   input  wire logic              low_freq_osc_on,
   input  wire logic              low_voltage_reset_flag,
   output logic                   pump_clk,
   output logic                   data_bank_select,
   output logic [1:0]             bias_level_com [NCOM],
   output logic [1:0]             bias_level_seg [NSEG],
   output logic [NSEG-1:0]        seg_lcd_en,
   output logic [NCOM-1:0]        com_lcd_en,
   output logic                   illegal_mode_write
);
   localparam int SLOT_W = 24;
   localparam int HALF_W = 16;

   logic [3:0]        pump_reg, mode_reg, disp_reg;
   logic [3:0]        ram_reg [2*NSEG];
   logic              wr_pend_reg;
   logic [11:0]       wr_addr_reg;
   logic [31:0]       hrdata_reg;
   logic              illegal_reg;
   logic [HALF_W-1:0] pump_cnt_reg;
   logic              pump_clk_reg;
   logic [SLOT_W-1:0] slot_cnt_reg;
   logic [2:0]        com_idx_reg;
   logic              phase_reg;
   logic              osc_s1_reg, osc_s2_reg, stop_s1_reg, stop_s2_reg;

   // Display RAM window test, shared by the write and read paths
   function automatic logic lcd_in_ram(input logic [11:0] idx);
      return (idx >= LCD_IDX_RAM_BASE) && (idx <= LCD_IDX_RAM_LAST);
   endfunction

   // Address decode for the bus
   wire        take      = hsel & hready & htrans[1];
   wire        rd_take   = take & ~hwrite;
   wire [11:0] rd_word   = {2'b00, haddr[11:2]};                     // Word index, byte address over four
   wire        pump_off  = pump_reg[LCD_PUMP_OFF_BIT];
   wire        disp_off  = disp_reg[LCD_BLANK_BIT];
   wire        four_com  = mode_reg[LCD_COM4_BIT];
   wire        ram_hit   = lcd_in_ram(wr_addr_reg);
   wire [6:0]  ram_wix   = 7'(wr_addr_reg - LCD_IDX_RAM_BASE);
   wire [6:0]  ram_rix   = 7'(rd_word - LCD_IDX_RAM_BASE);
   wire        ram_rhit  = lcd_in_ram(rd_word);

   // Oscillator-run and stop levels come from another domain
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         osc_s1_reg  <= 1'b0;
         osc_s2_reg  <= 1'b0;
         stop_s1_reg <= 1'b0;
         stop_s2_reg <= 1'b0;
      end else begin
         osc_s1_reg  <= low_freq_osc_on;
         osc_s2_reg  <= osc_s1_reg;
         stop_s1_reg <= cpu_stop;
         stop_s2_reg <= stop_s1_reg;
      end
   end

   // Driver clock alive: halt never stops it; stop keeps it only on low-frequency options
   wire lf_option = ~CK_OPTION[1];
   wire drv_run   = ~stop_s2_reg | (lf_option & osc_s2_reg);
   wire drv_live  = drv_run & ~pump_off;
   wire drv_show  = drv_live & ~disp_off;

   // Slot length picked by the clock option, each slot one common period
   wire [SLOT_W-1:0] slot_len = (CK_OPTION == LCD_CK_RC_XTAL) ? SLOT_W'(SLOT_XTAL) :
                                (CK_OPTION == LCD_CK_RC_RC32) ? SLOT_W'(SLOT_RC32) :
                                (CK_OPTION == LCD_CK_XTAL)    ? SLOT_W'(SLOT_XTAL) :
                                                                SLOT_W'(SLOT_RC200);
   wire [2:0] com_last = four_com ? 3'd3 : 3'd7;
   // Four commons get double-length slots, so the frame rate is the same in both duties
   wire [SLOT_W-1:0] slot_use = four_com ? {slot_len[SLOT_W-2:0], 1'b0} : slot_len;
   wire       slot_end = (slot_cnt_reg >= slot_use - 1'b1);

   // Register writes land in the data phase; mode writes with pump running are dropped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pump_reg    <= LCD_PUMP_RST;
         mode_reg    <= LCD_MODE_RST;
         disp_reg    <= LCD_DISP_RST;
         illegal_reg <= 1'b0;
      end else if (wr_pend_reg) begin
         if (wr_addr_reg == LCD_IDX_PUMP)
            pump_reg <= hwdata[3:0];
         if (wr_addr_reg == LCD_IDX_DISP)
            disp_reg <= {hwdata[LCD_BLANK_BIT], 3'b000};
         if (wr_addr_reg == LCD_IDX_MODE && pump_off)
            mode_reg <= hwdata[3:0];
         if (wr_addr_reg == LCD_IDX_MODE && !pump_off)
            illegal_reg <= 1'b1;
         if (wr_addr_reg == LCD_IDX_STATUS && hwdata[0])
            illegal_reg <= 1'b0;
      end
   end

   // Display RAM as flip-flops; CPU writes while the scan reads freely
   always_ff @(posedge hclk) begin
      if (wr_pend_reg && ram_hit)
         ram_reg[ram_wix] <= hwdata[3:0];
   end

   // Bus pipeline; reads answer in the data phase with zero wait
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 12'h0000;
         hrdata_reg  <= 32'h0000_0000;
      end else begin
         wr_pend_reg <= take & hwrite;
         wr_addr_reg <= rd_word;
         if (rd_take) begin
            if (rd_word == LCD_IDX_PUMP)
               hrdata_reg <= {28'h000_0000, pump_reg};
            else if (rd_word == LCD_IDX_DISP)
               hrdata_reg <= {28'h000_0000, disp_reg[3], low_voltage_reset_flag, 2'b00};
            else if (rd_word == LCD_IDX_STATUS)
               hrdata_reg <= {28'h000_0000, 1'b0, drv_show, drv_live, illegal_reg};
            else if (ram_rhit)
               hrdata_reg <= {28'h000_0000, ram_reg[ram_rix]};
            else
               hrdata_reg <= 32'h0000_0000;
         end
      end
   end

   // Pump clock divider, runs at 4 kHz while the pump is on and the driver clock is alive
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pump_cnt_reg <= '0;
         pump_clk_reg <= 1'b0;
      end else if (!drv_live) begin
         pump_cnt_reg <= '0;
         pump_clk_reg <= 1'b0;
      end else if (pump_cnt_reg == HALF_W'(LCD_PUMP_HALF - 1)) begin
         pump_cnt_reg <= '0;
         pump_clk_reg <= ~pump_clk_reg;
      end else begin
         pump_cnt_reg <= pump_cnt_reg + 1'b1;
      end
   end

   // Common scan: slot counter, common index, and frame polarity
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slot_cnt_reg <= '0;
         com_idx_reg  <= 3'd0;
         phase_reg    <= 1'b0;
      end else if (!drv_live) begin
         slot_cnt_reg <= '0;
         com_idx_reg  <= 3'd0;
         phase_reg    <= 1'b0;
      end else if (slot_end) begin
         slot_cnt_reg <= '0;
         if (com_idx_reg >= com_last) begin
            com_idx_reg <= 3'd0;
            phase_reg   <= ~phase_reg;
         end else begin
            com_idx_reg <= com_idx_reg + 1'b1;
         end
      end else begin
         slot_cnt_reg <= slot_cnt_reg + 1'b1;
      end
   end

   // Segment counts and released pins
   wire [6:0] seg_used = mode_reg[1] ? 7'd48 : (mode_reg[0] ? 7'd52 : 7'd56);

   // Level code 0 ground, 3 top; bias steps: selected full swing, else middle levels
   // Both modes use the 1/3 bias pair, levels 1 and 2; four-common swaps which level each phase takes.
   wire [1:0] lvl_hi  = 2'd3;
   wire [1:0] lvl_mid = four_com ? 2'd2 : 2'd1;
   wire [1:0] lvl_lo  = four_com ? 2'd1 : 2'd2;

   genvar gi;
   generate
      for (gi = 0; gi < NCOM; gi++) begin : g_com
         wire sel = (com_idx_reg == 3'(gi));
         assign com_lcd_en[gi] = !(four_com && gi >= 4);
         assign bias_level_com[gi] = (!drv_show || !com_lcd_en[gi]) ? 2'd0 :
                                     sel ? (phase_reg ? 2'd0 : lvl_hi) :
                                           (phase_reg ? lvl_lo : lvl_mid);
      end
      for (gi = 0; gi < NSEG; gi++) begin : g_seg
         wire [3:0] nib  = com_idx_reg[2] ? ram_reg[gi + NSEG] : ram_reg[gi];
         wire       on   = nib[com_idx_reg[1:0]];
         assign seg_lcd_en[gi] = (7'(gi) < seg_used);
         assign bias_level_seg[gi] = (!drv_show || !seg_lcd_en[gi]) ? 2'd0 :
                                     on ? (phase_reg ? lvl_hi : 2'd0) :
                                          (phase_reg ? lvl_mid : lvl_lo);
      end
   endgenerate

   // Outputs
   assign pump_clk           = pump_clk_reg;
   assign data_bank_select   = mode_reg[LCD_BANK_BIT];
   assign illegal_mode_write = illegal_reg;
   assign hrdata             = hrdata_reg;
   assign hreadyout          = 1'b1;
   assign hresp              = 1'b0;

   // Checks
   property p_pump_off_ground;
      @(posedge hclk) disable iff (!hresetn)
      pump_off |-> (bias_level_com[0] == 2'd0 && bias_level_seg[0] == 2'd0) ##1 !pump_clk;
   endproperty
   a_pump_off_ground: assert property (p_pump_off_ground) else $error("outputs not ground");

   property p_blank_low;
      @(posedge hclk) disable iff (!hresetn)
      disp_off |-> (bias_level_com[1] == 2'd0 && bias_level_seg[1] == 2'd0);
   endproperty
   a_blank_low: assert property (p_blank_low) else $error("blank not low");

   property p_mode_guard;
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && wr_addr_reg == LCD_IDX_MODE && !pump_off) |=> ($stable(mode_reg) && illegal_reg);
   endproperty
   a_mode_guard: assert property (p_mode_guard) else $error("mode written with pump on");

   property p_four_release;
      @(posedge hclk) disable iff (!hresetn)
      four_com |-> (!com_lcd_en[7] && com_lcd_en[3] && com_idx_reg <= 3'd3);
   endproperty
   a_four_release: assert property (p_four_release) else $error("four com release wrong");

   property p_seg48;
      @(posedge hclk) disable iff (!hresetn)
      mode_reg[1] |-> (!seg_lcd_en[48] && seg_lcd_en[47] && bias_level_seg[55] == 2'd0);
   endproperty
   a_seg48: assert property (p_seg48) else $error("48 segment release wrong");

   property p_pump_toggle;
      @(posedge hclk) disable iff (!hresetn)
      (drv_live && pump_cnt_reg == HALF_W'(LCD_PUMP_HALF - 1)) |=> (pump_clk != $past(pump_clk));
   endproperty
   a_pump_toggle: assert property (p_pump_toggle) else $error("pump clock not toggled");

   property p_write_pump;
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && wr_addr_reg == LCD_IDX_PUMP) |=> (pump_reg == $past(hwdata[3:0]));
   endproperty
   a_write_pump: assert property (p_write_pump) else $error("pump write lost");

   property p_stop_hold;
      @(posedge hclk) disable iff (!hresetn)
      (stop_s2_reg && CK_OPTION[1]) |-> (bias_level_com[0] == 2'd0) ##1 (pump_clk_reg == 1'b0);
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("driver ran in stop");

   // Blank write: address phase, then data phase, then the bit follows the data
   sequence s_disp_addr;
      take && hwrite && rd_word == LCD_IDX_DISP;
   endsequence
   sequence s_disp_data;
      wr_pend_reg && wr_addr_reg == LCD_IDX_DISP;
   endsequence
   property p_write_disp;
      @(posedge hclk) disable iff (!hresetn)
      s_disp_addr ##1 s_disp_data |=> (disp_off == $past(hwdata[LCD_BLANK_BIT]));
   endproperty
   a_write_disp: assert property (p_write_disp) else $error("blank write lost");

   property p_ram_write;
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && ram_hit) |=> (ram_reg[$past(ram_wix)] == $past(hwdata[3:0]));
   endproperty
   a_ram_write: assert property (p_ram_write) else $error("display ram write lost");

   property p_com_step;
      @(posedge hclk) disable iff (!hresetn)
      (drv_live && slot_end && com_idx_reg < com_last) |=>
         (com_idx_reg == $past(com_idx_reg) + 3'd1);
   endproperty
   a_com_step: assert property (p_com_step) else $error("common scan skipped");

   property p_frame_wrap;
      @(posedge hclk) disable iff (!hresetn)
      (drv_live && slot_end && com_idx_reg >= com_last) |=>
         (com_idx_reg == 3'd0 && phase_reg != $past(phase_reg));
   endproperty
   a_frame_wrap: assert property (p_frame_wrap) else $error("frame did not wrap");

   property p_seg52;
      @(posedge hclk) disable iff (!hresetn)
      (mode_reg[1:0] == 2'b01) |->
         (!seg_lcd_en[52] && seg_lcd_en[51] && bias_level_seg[52] == 2'd0);
   endproperty
   a_seg52: assert property (p_seg52) else $error("52 segment release wrong");

   property p_halt_run;
      @(posedge hclk) disable iff (!hresetn)
      (!stop_s2_reg && !pump_off) |=> (pump_cnt_reg != $past(pump_cnt_reg));
   endproperty
   a_halt_run: assert property (p_halt_run) else $error("driver stalled while running");

   property p_slot_bound;
      @(posedge hclk) disable iff (!hresetn)
      drv_live |-> (slot_cnt_reg < slot_use);
   endproperty
   a_slot_bound: assert property (p_slot_bound) else $error("slot overran its length");
endmodule
`default_nettype wire

/* File: testbench/lcd_panel_model.sv */
// Glass panel model: flags when any live electrode leaves ground
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
   input  wire logic        hclk,
   input  wire logic [1:0]  lvl_com [8],
   input  wire logic [1:0]  lvl_seg [56],
   input  wire logic [7:0]  com_en,
   input  wire logic [55:0] seg_en,
   output logic             lit
);
   // Passive glass: only pins still carrying waveform count, freed pins are port I/O
   always_ff @(posedge hclk) begin
      lit <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (com_en[i] && lvl_com[i] != 2'd0) lit <= 1'b1;
      end
      for (int i = 0; i < 56; i++) begin
         if (seg_en[i] && lvl_seg[i] != 2'd0) lit <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: testbench/tb_lcd_driver_control.sv */
// Testbench for the LCD control block: bus tasks, reference model, scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_lcd_driver_control
   import lcd_pkg::*;
   ;
   logic        hclk = 1'b0;
   logic        hresetn, hsel, hwrite, hrdy, hresp, cpu_stop, osc_on, lvf;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic        pump_clk, bank, illegal, lit;
   logic [1:0]  lvl_com [8];
   logic [1:0]  lvl_seg [56];
   logic [55:0] seg_en;
   logic [7:0]  com_en;
   logic        pclk2, lit2;
   logic [1:0]  lvl_com2 [8];
   logic [1:0]  lvl_seg2 [56];
   logic [55:0] seg_en2;
   logic [7:0]  com_en2;
   logic [3:0]  pump_m, disp_m, mode_m;
   logic [3:0]  ram_m [int];
   int          fail_count = 0;
   int          n_tests = 0;
   int          n, k;

   // 4 ns period
   always #2 hclk = ~hclk;

   // Short common slots keep frames inside the run budget
   lcd_driver_control #(.SLOT_XTAL(10), .SLOT_RC32(10), .SLOT_RC200(10)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
      .hreadyout(hrdy), .hresp(hresp), .cpu_stop(cpu_stop), .low_freq_osc_on(osc_on),
      .low_voltage_reset_flag(lvf), .pump_clk(pump_clk), .data_bank_select(bank),
      .bias_level_com(lvl_com), .bias_level_seg(lvl_seg), .seg_lcd_en(seg_en),
      .com_lcd_en(com_en), .illegal_mode_write(illegal));

   lcd_panel_model u_panel (.hclk(hclk), .lvl_com(lvl_com), .lvl_seg(lvl_seg),
      .com_en(com_en), .seg_en(seg_en), .lit(lit));

   // Second part on the system-clock option: its driver must halt in stop mode
   lcd_driver_control #(.SLOT_XTAL(10), .SLOT_RC32(10), .SLOT_RC200(10),
      .CK_OPTION(2'b10)) u_dut_sys (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(),
      .hreadyout(), .hresp(), .cpu_stop(cpu_stop), .low_freq_osc_on(osc_on),
      .low_voltage_reset_flag(lvf), .pump_clk(pclk2), .data_bank_select(),
      .bias_level_com(lvl_com2), .bias_level_seg(lvl_seg2), .seg_lcd_en(seg_en2),
      .com_lcd_en(com_en2), .illegal_mode_write());

   lcd_panel_model u_panel_sys (.hclk(hclk), .lvl_com(lvl_com2), .lvl_seg(lvl_seg2),
      .com_en(com_en2), .seg_en(seg_en2), .lit(lit2));

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Bounded wait for hready; a stuck slave ends the run
   task automatic wait_rdy();
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hrdy !== 1'b1 && i < 64);
      if (hrdy !== 1'b1) begin
         fail_count++;
         stop_test();
      end
   endtask

   // One single word transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {a[9:0], 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
      chk(hresp, 1'b0);
   endtask

   // Reference model follows every write; mode is locked while the pump runs
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      if (a == LCD_IDX_PUMP) pump_m = d[3:0];
      if (a == LCD_IDX_MODE && pump_m[LCD_PUMP_OFF_BIT]) mode_m = d[3:0];
      if (a == LCD_IDX_DISP) disp_m = {d[3], 3'b000};
      if (a >= LCD_IDX_RAM_BASE && a <= LCD_IDX_RAM_LAST) ram_m[a] = d[3:0];
      bus(1'b1, a, d);
   endtask

   task automatic rdc(input logic [11:0] a);
      logic [3:0] e;
      e = 4'h0;
      if (a == LCD_IDX_PUMP) e = pump_m;
      if (a == LCD_IDX_DISP) e = {disp_m[3], lvf, 2'b00};
      if (ram_m.exists(a)) e = ram_m[a];
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, {28'h0, e});
   endtask

   // Watch the glass for a while; any lit sample counts
   task automatic see_lit(input logic exp);
      logic any;
      any = 1'b0;
      repeat (3) @(posedge hclk);
      repeat (400) begin
         @(posedge hclk);
         any = any | (lit === 1'b1);
      end
      chk(any, exp);
   endtask

   task automatic wait_pc(input logic v);
      k = 0;
      while (pump_clk === v && k < 70000) begin
         @(negedge hclk);
         k++;
      end
      if (k >= 70000) begin
         fail_count++;
         stop_test();
      end
   endtask

   // Main sequence
   initial begin
      void'($urandom(75));
      {hresetn, hsel, hwrite, cpu_stop, osc_on, lvf} = 6'b000001;
      haddr = 12'h000;
      htrans = 2'b00;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      {pump_m, disp_m, mode_m} = {LCD_PUMP_RST, LCD_DISP_RST, LCD_MODE_RST};
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdc(LCD_IDX_PUMP);
      rdc(LCD_IDX_DISP);
      rdc(LCD_IDX_MODE);
      rdc(12'h040);
      chk({pump_clk, lit, bank, com_en}, {3'b000, 8'hff});
      chk(seg_en, {56{1'b1}});
      $display("reset test done");
      for (int m = 0; m < 17; m++) begin
         wr(LCD_IDX_MODE, 32'(m % 16));
         @(negedge hclk);
         n = mode_m[1] ? 48 : (mode_m[0] ? 52 : 56);
         chk(seg_en, (64'h1 << n) - 64'h1);
         chk(com_en, mode_m[2] ? 8'h0f : 8'hff);
         chk(bank, mode_m[3]);
         @(posedge hclk);
      end
      $display("mode test done");
      wr(LCD_IDX_DISP, 32'h0000_0008);
      osc_on <= 1'b1;
      for (int i = 0; i < 28; i++) wr(LCD_IDX_RAM_BASE + 12'(i), $urandom_range(15, 1));
      for (int i = 0; i < 28; i++) rdc(LCD_IDX_RAM_BASE + 12'(i));
      wr(LCD_IDX_DISP, 32'h0000_0000);
      see_lit(1'b0);
      wr(LCD_IDX_PUMP, $urandom & 32'h0000_000b);
      rdc(LCD_IDX_PUMP);
      wait_pc(1'b0);
      wait_pc(1'b1);
      chk(k, LCD_PUMP_HALF);
      see_lit(1'b1);
      chk(lit2, 1'b1);
      $display("pump test done");
      wr(LCD_IDX_MODE, 32'h0000_000f);
      @(negedge hclk);
      chk({illegal, bank, com_en}, {2'b10, 8'hff});
      chk(seg_en, {56{1'b1}});
      @(posedge hclk);
      bus(1'b0, LCD_IDX_STATUS, 32'h0);
      chk(rd[0], 1'b1);
      wr(LCD_IDX_STATUS, 32'h0000_0001);
      bus(1'b0, LCD_IDX_STATUS, 32'h0);
      chk(rd[0], 1'b0);
      $display("illegal write test done");
      cpu_stop <= 1'b1;
      see_lit(1'b1);
      chk({pclk2, lit2}, 2'b00);
      cpu_stop <= 1'b0;
      wr(LCD_IDX_DISP, 32'h0000_000f);
      rdc(LCD_IDX_DISP);
      see_lit(1'b0);
      wr(LCD_IDX_DISP, 32'h0000_0000);
      wr(LCD_IDX_PUMP, 32'h0000_0004);
      see_lit(1'b0);
      chk(pump_clk, 1'b0);
      $display("blank test done");
      stop_test();
   end
endmodule
`default_nettype wire
